// ==== hdl/bfc_map.svh ====
// constants for the branch and flow-control unit
`ifndef BFC_MAP_SVH
`define BFC_MAP_SVH
`define BFC_XLEN            32
`define BFC_NUM_FIELDS      8
`define BFC_FIELD_W         4
`define BFC_CR_RESET        32'h0000_0000
`define BFC_ADDR_RESET      32'h0000_0000
`define BFC_TRAP_VECTOR     32'h0000_0700
`define BFC_SYSCALL_VECTOR  32'h0000_0c00
`define BFC_MC_LATENCY      3'h3
`define BFC_INFLIGHT        4
// special register numbers
`define BFC_SPR_XER         10'h001
`define BFC_SPR_LINK        10'h008
`define BFC_SPR_COUNT       10'h009
// trap condition select bits
`define BFC_TO_LT           4
`define BFC_TO_GT           3
`define BFC_TO_EQ           2
`define BFC_TO_LTU          1
`define BFC_TO_GTU          0
// branch option bits
`define BFC_BO_NOCOND       4
`define BFC_BO_SENSE        3
`define BFC_BO_NOCTR        2
`define BFC_BO_CTRZ         1
`endif

// ==== hdl/bfc_pkg.sv ====
// types for the branch and flow-control unit
package bfc_pkg;
    typedef enum logic [4:0] {
        BFC_OP_NOP,
        BFC_OP_B_REL,
        BFC_OP_B_ABS,
        BFC_OP_BC_REL,
        BFC_OP_BC_ABS,
        BFC_OP_BC_LINK,
        BFC_OP_BC_COUNT,
        BFC_OP_CR_LOGIC,
        BFC_OP_CR_COPY,
        BFC_OP_TRAP_IMM,
        BFC_OP_TRAP_REG,
        BFC_OP_SYSCALL,
        BFC_OP_MT_FIELDS,
        BFC_OP_MT_XER,
        BFC_OP_MF_CR,
        BFC_OP_MT_SPR,
        BFC_OP_MF_SPR
    } bfc_op_t;

    typedef enum logic [1:0] {
        BFC_U_BRANCH,
        BFC_U_SINGLE,
        BFC_U_MULTI,
        BFC_U_NONE
    } bfc_unit_t;

    // one dispatched operation
    typedef struct packed {
        logic        valid;
        bfc_op_t     op;
        logic [31:0] pc;
        logic [23:0] disp;
        logic        link;
        logic [4:0]  bo;
        logic [4:0]  bi;
        logic [4:0]  ba;
        logic [4:0]  bb;
        logic [3:0]  logic_fn;
        logic [2:0]  fd;
        logic [2:0]  fs;
        logic [7:0]  fmask;
        logic [4:0]  to;
        logic [31:0] ra;
        logic [31:0] rb;
        logic [9:0]  special_purpose_reg;
        logic        predict_taken;
    } bfc_issue_t;

    // redirect toward fetch
    typedef struct packed {
        logic        valid;
        logic        flush;
        logic        trap;
        logic        syscall;
        logic        invalid;
        logic [31:0] addr;
    } bfc_redir_t;

    // general register write back
    typedef struct packed {
        logic        valid;
        logic [31:0] data;
    } bfc_wb_t;
endpackage

// ==== hdl/bfc_unit.sv ====
// branch and flow-control unit: branches, cond flags ops, traps, moves
`timescale 1ns/1ps
`include "bfc_map.svh"

module bfc_unit
    import bfc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire bfc_issue_t  issue,
    input  wire logic [31:0] pending_bits,
    input  wire logic        mc_done,
    input  wire logic [31:0] xer_in,
    output bfc_redir_t       redir,
    output bfc_wb_t          wb,
    output logic [31:0]      cond_flags_reg,
    output logic [31:0]      return_addr_reg,
    output logic [31:0]      count_reg,
    output logic             stall,
    output logic             predict_ok,
    output logic             mispredict,
    output bfc_unit_t        steer,
    output logic             sb_busy
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] align_word(input logic [31:0] a);
        align_word = {a[31:2], 2'b00};
    endfunction

    function automatic logic [3:0] count_ones(input logic [7:0] m);
        logic [3:0] n;
        n = 4'h0;
        for (int i = 0; i < 8; i++)
            n = n + {3'h0, m[i]};
        count_ones = n;
    endfunction

    // cond flag bit numbering: bit 0 is the msb of field 0
    function automatic logic get_bit(input logic [31:0] c,
                                     input logic [4:0] i);
        get_bit = c[5'd31 - i];
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [31:0] cr_q, cr_d;
    logic [31:0] lr_q, lr_d;
    logic [31:0] ctr_q, ctr_d;
    logic        sb_q, sb_d;
    logic [2:0]  mc_cnt_q;
    bfc_redir_t  redir_q, redir_d;
    bfc_wb_t     wb_q, wb_d;
    logic        ok_q, miss_q;
    bfc_unit_t   steer_q, steer_d;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire logic is_bc = issue.op inside {BFC_OP_BC_REL, BFC_OP_BC_ABS,
                                        BFC_OP_BC_LINK, BFC_OP_BC_COUNT};
    wire logic is_crop = issue.op inside {BFC_OP_CR_LOGIC, BFC_OP_CR_COPY};
    wire logic [3:0] nfields = count_ones(issue.fmask);
    wire logic mt_single = issue.op == BFC_OP_MT_FIELDS && nfields == 4'h1;
    wire logic mt_multi  = issue.op == BFC_OP_MT_FIELDS && nfields != 4'h1;
    wire logic mt_ctr_lr = issue.op == BFC_OP_MT_SPR &&
                           (issue.special_purpose_reg == `BFC_SPR_LINK ||
                            issue.special_purpose_reg == `BFC_SPR_COUNT);
    wire logic cond_dep = is_bc && !issue.bo[`BFC_BO_NOCOND];
    // every branch kind gets a prediction mark
    wire logic is_br = is_bc || (issue.op inside {BFC_OP_B_REL, BFC_OP_B_ABS});

    // dependent ops wait while the scoreboard is set
    wire logic sb_block = sb_q && (mt_multi || mt_ctr_lr ||
                                   cond_dep || is_crop);
    // a pending update of the tested bit holds the branch
    wire logic cr_lock = cond_dep && pending_bits[5'd31 - issue.bi];
    wire logic go = issue.valid && !sb_block && !cr_lock;

    // ------------------------------------------------------------
    // branch resolution
    // ------------------------------------------------------------
    wire logic [31:0] ctr_dec = ctr_q - 32'h1;
    wire logic dec_ctr = is_bc && !issue.bo[`BFC_BO_NOCTR] &&
                         issue.op != BFC_OP_BC_COUNT;
    wire logic ctr_ok = !dec_ctr ||
                        ((ctr_dec == 32'h0) == issue.bo[`BFC_BO_CTRZ]);
    wire logic cond_ok = issue.bo[`BFC_BO_NOCOND] ||
                         (get_bit(cr_q, issue.bi) == issue.bo[`BFC_BO_SENSE]);
    wire logic taken = (issue.op inside {BFC_OP_B_REL, BFC_OP_B_ABS}) ||
                       (is_bc && ctr_ok && cond_ok);
    wire logic [31:0] disp_x = {{6{issue.disp[23]}}, issue.disp, 2'b00};
    wire logic [31:0] disp_c = {{16{issue.disp[13]}}, issue.disp[13:0],
                                2'b00};
    wire logic [31:0] pc_next = issue.pc + 32'h4;

    logic [31:0] target;
    always_comb
    begin
        // six addressing modes
        unique case (issue.op)
            BFC_OP_B_REL:    target = issue.pc + disp_x;
            BFC_OP_B_ABS:    target = disp_x;
            BFC_OP_BC_REL:   target = issue.pc + disp_c;
            BFC_OP_BC_ABS:   target = disp_c;
            BFC_OP_BC_LINK:  target = lr_q;
            BFC_OP_BC_COUNT: target = ctr_q;
            default:         target = pc_next;
        endcase
    end

    // ------------------------------------------------------------
    // flag logic and trap compare
    // ------------------------------------------------------------
    wire logic bit_a = get_bit(cr_q, issue.ba);
    wire logic bit_b = get_bit(cr_q, issue.bb);
    // fn is the truth table indexed by {a,b}
    wire logic crl_res = issue.logic_fn[{bit_a, bit_b}];
    wire logic [31:0] topnd = (issue.op == BFC_OP_TRAP_IMM) ?
                              {{16{issue.rb[15]}}, issue.rb[15:0]} :
                              issue.rb;
    wire logic tr_hit =
        (issue.to[`BFC_TO_LT]  && $signed(issue.ra) < $signed(topnd)) ||
        (issue.to[`BFC_TO_GT]  && $signed(issue.ra) > $signed(topnd)) ||
        (issue.to[`BFC_TO_EQ]  && issue.ra == topnd) ||
        (issue.to[`BFC_TO_LTU] && issue.ra < topnd) ||
        (issue.to[`BFC_TO_GTU] && issue.ra > topnd);
    wire logic [31:0] fmask_bits = {{4{issue.fmask[7]}}, {4{issue.fmask[6]}},
                                    {4{issue.fmask[5]}}, {4{issue.fmask[4]}},
                                    {4{issue.fmask[3]}}, {4{issue.fmask[2]}},
                                    {4{issue.fmask[1]}}, {4{issue.fmask[0]}}};

    always_comb
    begin
        cr_d    = cr_q;
        lr_d    = lr_q;
        ctr_d   = ctr_q;
        sb_d    = sb_q;
        redir_d = '0;
        wb_d    = '0;
        steer_d = BFC_U_NONE;
        if (sb_q && mc_done)
            sb_d = 1'b0;
        if (go)
        begin
            unique case (issue.op)
                BFC_OP_B_REL, BFC_OP_B_ABS, BFC_OP_BC_REL, BFC_OP_BC_ABS,
                BFC_OP_BC_LINK, BFC_OP_BC_COUNT:
                begin
                    steer_d = BFC_U_BRANCH;
                    if (dec_ctr)
                        ctr_d = ctr_dec;
                    if (issue.link)
                        lr_d = pc_next;
                    // redirect only on a wrong guess
                    redir_d.valid = taken != issue.predict_taken;
                    redir_d.flush = taken != issue.predict_taken;
                    redir_d.addr  = align_word(taken ? target : pc_next);
                end
                BFC_OP_CR_LOGIC, BFC_OP_CR_COPY:
                begin
                    steer_d = BFC_U_BRANCH;
                    if (issue.link)
                    begin
                        redir_d.valid   = 1'b1;
                        redir_d.invalid = 1'b1;
                        redir_d.flush   = 1'b1;
                        redir_d.addr    = `BFC_TRAP_VECTOR;
                    end
                    else if (issue.op == BFC_OP_CR_LOGIC)
                        cr_d[5'd31 - issue.bb] = cr_d[5'd31 - issue.bb];
                    if (!issue.link && issue.op == BFC_OP_CR_LOGIC)
                        cr_d[5'd31 - issue.bi] = crl_res;
                    if (!issue.link && issue.op == BFC_OP_CR_COPY)
                        // field copy
                        cr_d[(3'd7 - issue.fd) * 4 +: 4] =
                            cr_q[(3'd7 - issue.fs) * 4 +: 4];
                end
                BFC_OP_TRAP_IMM, BFC_OP_TRAP_REG:
                begin
                    steer_d       = BFC_U_BRANCH;
                    redir_d.valid = tr_hit;
                    redir_d.trap  = tr_hit;
                    redir_d.flush = tr_hit;
                    redir_d.addr  = `BFC_TRAP_VECTOR;
                end
                BFC_OP_SYSCALL:
                begin
                    steer_d         = BFC_U_BRANCH;
                    redir_d.valid   = 1'b1;
                    redir_d.syscall = 1'b1;
                    redir_d.flush   = 1'b1;
                    redir_d.addr    = `BFC_SYSCALL_VECTOR;
                end
                BFC_OP_MT_FIELDS:
                begin
                    // masked field write
                    cr_d = (cr_q & ~fmask_bits) | (issue.ra & fmask_bits);
                    if (mt_single)
                        steer_d = BFC_U_SINGLE;
                    else
                    begin
                        steer_d = BFC_U_MULTI;
                        sb_d    = 1'b1;
                    end
                end
                BFC_OP_MT_XER:
                begin
                    steer_d = BFC_U_SINGLE;
                    cr_d[(3'd7 - issue.fd) * 4 +: 4] = xer_in[31:28];
                end
                BFC_OP_MF_CR:
                begin
                    steer_d = BFC_U_SINGLE;
                    wb_d    = '{valid: 1'b1, data: cr_q};
                end
                BFC_OP_MT_SPR:
                begin
                    steer_d = BFC_U_MULTI;
                    if (issue.special_purpose_reg == `BFC_SPR_LINK)
                        lr_d = issue.ra;
                    if (issue.special_purpose_reg == `BFC_SPR_COUNT)
                        ctr_d = issue.ra;
                    if (mt_ctr_lr)
                        sb_d = 1'b1;
                end
                BFC_OP_MF_SPR:
                begin
                    steer_d = BFC_U_MULTI;
                    wb_d.valid = 1'b1;
                    wb_d.data  = (issue.special_purpose_reg == `BFC_SPR_LINK)  ? lr_q :
                                 (issue.special_purpose_reg == `BFC_SPR_COUNT) ? ctr_q :
                                 (issue.special_purpose_reg == `BFC_SPR_XER)   ? xer_in :
                                 32'h0;
                end
                default:
                    steer_d = BFC_U_NONE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cr_q    <= `BFC_CR_RESET;
            lr_q    <= `BFC_ADDR_RESET;
            ctr_q   <= `BFC_ADDR_RESET;
            sb_q    <= 1'b0;
            redir_q <= '0;
            wb_q    <= '0;
            ok_q    <= 1'b0;
            miss_q  <= 1'b0;
            steer_q <= BFC_U_NONE;
        end
        else
        begin
            cr_q    <= cr_d;
            lr_q    <= lr_d;
            ctr_q   <= ctr_d;
            sb_q    <= sb_d;
            redir_q <= redir_d;
            wb_q    <= wb_d;
            ok_q    <= go && is_br && taken == issue.predict_taken;
            miss_q  <= go && is_br && taken != issue.predict_taken;
            steer_q <= steer_d;
        end
    end

    assign redir           = redir_q;
    assign wb              = wb_q;
    assign cond_flags_reg  = cr_q;
    assign return_addr_reg = lr_q;
    assign count_reg       = ctr_q;
    assign stall           = issue.valid && !go;
    assign predict_ok      = ok_q;
    assign mispredict      = miss_q;
    assign steer           = steer_q;
    assign sb_busy         = sb_q;

    wire logic unused_ok = &{1'b0, mc_cnt_q, xer_in[27:0]};
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            mc_cnt_q <= 3'h0;
        else
            mc_cnt_q <= 3'h0;
    end

endmodule

// ==== tb/bfc_unit_assertions.sv ====
// concurrent checks on the branch and flow-control unit ports
`timescale 1ns/1ps
`include "bfc_map.svh"

module bfc_unit_chk
    import bfc_pkg::*;
(
    input wire logic        clk,
    input wire logic        rst_b,
    input wire bfc_issue_t  issue,
    input wire logic [31:0] pending_bits,
    input wire logic        mc_done,
    input wire bfc_redir_t  redir,
    input wire logic [31:0] cond_flags_reg,
    input wire logic        stall,
    input wire logic        predict_ok,
    input wire logic        mispredict,
    input wire bfc_unit_t   steer,
    input wire logic        sb_busy
);
    // ----------------------------------------------------------------
    // request decode
    // ----------------------------------------------------------------
    wire logic acc = issue.valid && !stall;
    wire logic brn = issue.op inside {[BFC_OP_B_REL:BFC_OP_BC_COUNT]};
    wire logic cbr = issue.op inside {[BFC_OP_BC_REL:BFC_OP_BC_COUNT]}
        && !issue.bo[`BFC_BO_NOCOND];
    wire logic flg = issue.op inside {BFC_OP_CR_LOGIC, BFC_OP_CR_COPY};
    wire logic mtf = issue.op == BFC_OP_MT_FIELDS;
    wire logic one = $onehot(issue.fmask);
    wire logic trp = issue.op inside {BFC_OP_TRAP_IMM, BFC_OP_TRAP_REG};
    wire logic special_purpose_reg = issue.op == BFC_OP_MT_SPR
        && (issue.special_purpose_reg == `BFC_SPR_LINK || issue.special_purpose_reg == `BFC_SPR_COUNT);
    wire logic sbo = cbr || flg || (mtf && !one) || special_purpose_reg;

    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    pend_stall_a:
        assert property (issue.valid && cbr
            && pending_bits[5'd31 - issue.bi] |-> stall)
        else $error("branch accepted over pending flag bit");
    word_align_a:
        assert property (redir.valid |-> redir.addr[1:0] == 2'h0)
        else $error("redirect target not word aligned");
    branch_unit_a:
        assert property (acc && (brn || (flg && !issue.link))
            |=> steer == BFC_U_BRANCH)
        else $error("flow op not steered to branch unit");
    resolve_mark_a:
        assert property (acc && cbr |=> (predict_ok ^ mispredict)
            && (mispredict == (redir.valid && redir.flush)))
        else $error("branch not marked or miss not flushed");
    bad_form_a:
        assert property (acc && flg && issue.link |=> redir.valid
            && redir.invalid && $stable(cond_flags_reg))
        else $error("invalid flag op form not refused");
    trap_vec_a:
        assert property (acc && trp |=> !redir.valid
            || (redir.trap && redir.addr == `BFC_TRAP_VECTOR))
        else $error("trap redirect wrong");
    sys_call_a:
        assert property (acc && issue.op == BFC_OP_SYSCALL |=> redir.valid
            && redir.syscall && redir.addr == `BFC_SYSCALL_VECTOR)
        else $error("system call redirect wrong");
    one_field_a:
        assert property (acc && mtf && one |=> steer == BFC_U_SINGLE)
        else $error("single field move not on single unit");
    multi_field_a:
        assert property (acc && mtf && !one
            |=> steer == BFC_U_MULTI && sb_busy)
        else $error("multi field move did not set scoreboard");
    sb_stall_a:
        assert property (sb_busy && issue.valid && sbo |-> stall)
        else $error("dependent op dispatched while scoreboard set");
    sb_clear_a:
        assert property (sb_busy && mc_done |=> !sb_busy)
        else $error("scoreboard not cleared on finish");
    par_field_a:
        assert property (sb_busy && issue.valid && mtf && one |-> !stall)
        else $error("single field move held by scoreboard");
endmodule

bind bfc_unit bfc_unit_chk u_chk (
    .clk(clk), .rst_b(rst_b), .issue(issue),
    .pending_bits(pending_bits), .mc_done(mc_done), .redir(redir),
    .cond_flags_reg(cond_flags_reg), .stall(stall),
    .predict_ok(predict_ok), .mispredict(mispredict),
    .steer(steer), .sb_busy(sb_busy)
);

// ==== tb/bfc_mc_model.sv ====
// model of the multi-cycle integer unit beside the branch unit
`timescale 1ns/1ps

module bfc_mc_model
    import bfc_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      rst_b,
    input  wire bfc_unit_t steer,
    input  wire logic      slow,
    output logic           mc_done
);
    logic [3:0] cnt_q;

    // finish a multi-cycle op after a short or a long run
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cnt_q   <= 4'h0;
            mc_done <= 1'b0;
        end
        else
        begin
            mc_done <= cnt_q == 4'h1;
            if (steer == BFC_U_MULTI)
                cnt_q <= slow ? 4'hc : 4'h3;
            else if (cnt_q != 4'h0)
                cnt_q <= cnt_q - 4'h1;
        end
    end
endmodule

// ==== tb/tb_branch_flow_control_unit.sv ====
// self-checking bench for the branch and flow-control unit
`timescale 1ns/1ps

module tb_branch_flow_control_unit
    import bfc_pkg::*;
();
    typedef struct {
        bfc_op_t     op;
        logic [4:0]  bo;
        logic [31:0] ra;
        logic [31:0] rb;
        logic        pr;
        logic        rv;
        logic [31:0] ad;
    } bfc_row_t;
    logic        clk = 1'b0;
    logic        rst_b = 1'b0;
    bfc_issue_t  issue = '0;
    logic [31:0] pending_bits = 32'h0;
    logic [31:0] xer_in = 32'h0;
    logic        slow = 1'b0;
    logic        mc_done, stall, predict_ok, mispredict, sb_busy;
    bfc_redir_t  redir;
    bfc_wb_t     wb;
    logic [31:0] cond_flags_reg, return_addr_reg, count_reg;
    bfc_unit_t   steer;
    bfc_issue_t  x;
    bfc_issue_t  sx [6];
    int          bad_count = 0;
    int          cmp_count = 0;
    bfc_row_t rows [14] = '{
        '{BFC_OP_B_REL, 5'h00, 32'h0, 32'h0, 1'b0, 1'b1, 32'h104c},
        '{BFC_OP_B_ABS, 5'h00, 32'h0, 32'h0, 1'b0, 1'b1, 32'h4c},
        '{BFC_OP_BC_REL, 5'h0c, 32'h0, 32'h0, 1'b1, 1'b1, 32'h1004},
        '{BFC_OP_BC_REL, 5'h0c, 32'h0, 32'h0, 1'b0, 1'b0, 32'h0},
        '{BFC_OP_BC_ABS, 5'h00, 32'h0, 32'h0, 1'b0, 1'b1, 32'h4c},
        '{BFC_OP_BC_LINK, 5'h14, 32'h0, 32'h0, 1'b0, 1'b1, 32'h2220},
        '{BFC_OP_BC_COUNT, 5'h14, 32'h0, 32'h0, 1'b0, 1'b1, 32'h3334},
        '{BFC_OP_TRAP_REG, 5'h04, 32'h5, 32'h5, 1'b0, 1'b1, 32'h700},
        '{BFC_OP_TRAP_REG, 5'h10, 32'h5, 32'h5, 1'b0, 1'b0, 32'h0},
        '{BFC_OP_TRAP_REG, 5'h08, 32'h6, 32'h5, 1'b0, 1'b1, 32'h700},
        '{BFC_OP_TRAP_REG, 5'h01, 32'h1, '1, 1'b0, 1'b0, 32'h0},
        '{BFC_OP_TRAP_IMM, 5'h10, '1, 32'h0, 1'b0, 1'b1, 32'h700},
        '{BFC_OP_TRAP_IMM, 5'h02, '1, 32'h1, 1'b0, 1'b0, 32'h0},
        '{BFC_OP_SYSCALL, 5'h00, 32'h0, 32'h0, 1'b0, 1'b1, 32'hc00}
    };

    always #25 clk = ~clk;

    bfc_unit dut (
        .clk(clk), .rst_b(rst_b), .issue(issue),
        .pending_bits(pending_bits), .mc_done(mc_done), .xer_in(xer_in),
        .redir(redir), .wb(wb), .cond_flags_reg(cond_flags_reg),
        .return_addr_reg(return_addr_reg), .count_reg(count_reg),
        .stall(stall), .predict_ok(predict_ok), .mispredict(mispredict),
        .steer(steer), .sb_busy(sb_busy)
    );
    bfc_mc_model u_mc (
        .clk(clk), .rst_b(rst_b), .steer(steer), .slow(slow),
        .mc_done(mc_done)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic err(input logic [31:0] g, input logic [31:0] e);
        bad_count++;
        $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    endtask
    task automatic chkv(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
            err(g, e);
    endtask
    task automatic chkb(input logic g, input logic e);
        cmp_count++;
        if (g !== e)
            err({31'h0, g}, {31'h0, e});
    endtask
    task automatic chku(input bfc_unit_t g, input bfc_unit_t e);
        cmp_count++;
        if (g !== e)
            err({30'h0, g}, {30'h0, e});
    endtask
    function automatic bfc_issue_t mk(bfc_op_t op, logic [4:0] bo,
        logic [31:0] ra);
        bfc_issue_t r;
        r = '0;
        r.valid = 1'b1;
        r.op = op;
        r.bo = bo;
        r.to = bo;
        r.ra = ra;
        r.pc = 32'h1000;
        r.disp = 24'h13;
        return r;
    endfunction
    // present an op, hold it while refused, end where results stand
    task automatic go(input bfc_issue_t r);
        int n;
        @(negedge clk);
        issue = r;
        n = 0;
        #1;
        while (stall !== 1'b0 && n < 50)
        begin
            @(negedge clk);
            #1;
            n++;
        end
        @(negedge clk);
        issue = '0;
    endtask
    task automatic wait_free();
        int n;
        for (n = 0; n < 30 && sb_busy !== 1'b0; n++)
            @(negedge clk);
        chkb(sb_busy, 1'b0);
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial
    begin
        #(2000 * 50);
        bad_count++;
        complete_run();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        repeat (20) @(posedge clk);
        @(negedge clk);
        rst_b = 1'b1;
        x = mk(BFC_OP_MT_SPR, 5'h0, 32'h2223);
        x.special_purpose_reg = 10'h008;
        go(x);
        chkv(return_addr_reg, 32'h2223);
        x.special_purpose_reg = 10'h009;
        x.ra = 32'h3337;
        go(x);
        chkv(count_reg, 32'h3337);
        x.op = BFC_OP_MF_SPR;
        go(x);
        chkb(wb.valid, 1'b1);
        chkv(wb.data, 32'h3337);
        foreach (rows[i])
        begin
            x = mk(rows[i].op, rows[i].bo, rows[i].ra);
            x.rb = rows[i].rb;
            x.predict_taken = rows[i].pr;
            go(x);
            chkb(redir.valid, rows[i].rv);
            chkb(mispredict, rows[i].rv && i < 7);
            chkb(predict_ok, !rows[i].rv && i < 7);
            if (rows[i].rv)
                chkv(redir.addr, rows[i].ad);
        end
        chkv(count_reg, 32'h3336);
        $display("test table done");
        x = mk(BFC_OP_MT_FIELDS, 5'h0, 32'hf000_0000);
        x.fmask = 8'h80;
        go(x);
        chku(steer, BFC_U_SINGLE);
        chkv(cond_flags_reg, 32'hf000_0000);
        x = mk(BFC_OP_CR_LOGIC, 5'h08, 32'h0);
        x.bi = 5'd8;
        x.bb = 5'd4;
        x.logic_fn = 4'h6;
        go(x);
        chku(steer, BFC_U_BRANCH);
        chkv(cond_flags_reg, 32'hf080_0000);
        x.op = BFC_OP_CR_COPY;
        x.fd = 3'd2;
        go(x);
        chkv(cond_flags_reg, 32'hf0f0_0000);
        x.op = BFC_OP_CR_LOGIC;
        x.link = 1'b1;
        go(x);
        chkb(redir.invalid, 1'b1);
        chkv(cond_flags_reg, 32'hf0f0_0000);
        xer_in = 32'ha000_0000;
        x = mk(BFC_OP_MT_XER, 5'h0, 32'h0);
        x.fd = 3'd1;
        go(x);
        x.op = BFC_OP_MF_CR;
        go(x);
        chkv(wb.data, 32'hfaf0_0000);
        $display("test flag ops done");
        x = mk(BFC_OP_BC_REL, 5'h0c, 32'h0);
        x.bi = 5'd4;
        x.predict_taken = 1'b1;
        @(negedge clk);
        pending_bits = 32'h0800_0000;
        issue = x;
        #1 chkb(stall, 1'b1);
        @(negedge clk);
        pending_bits = 32'h0;
        #1 chkb(stall, 1'b0);
        @(negedge clk);
        issue = '0;
        chkb(predict_ok, 1'b1);
        $display("test interlock done");
        slow = 1'b1;
        x = mk(BFC_OP_MT_FIELDS, 5'h0, 32'h5000_000a);
        x.fmask = 8'h81;
        go(x);
        chku(steer, BFC_U_MULTI);
        chkb(sb_busy, 1'b1);
        chkv(cond_flags_reg, 32'h5af0_000a);
        sx[0] = mk(BFC_OP_MT_FIELDS, 5'h0, 32'h0);
        sx[1] = mk(BFC_OP_MT_SPR, 5'h0, 32'h0);
        sx[1].special_purpose_reg = 10'h008;
        sx[2] = sx[1];
        sx[2].special_purpose_reg = 10'h009;
        sx[3] = mk(BFC_OP_BC_REL, 5'h0c, 32'h0);
        sx[4] = mk(BFC_OP_CR_LOGIC, 5'h0, 32'h0);
        sx[5] = mk(BFC_OP_CR_COPY, 5'h0, 32'h0);
        foreach (sx[i])
        begin
            @(negedge clk);
            issue = sx[i];
            #1 chkb(stall, 1'b1);
        end
        x = mk(BFC_OP_MT_FIELDS, 5'h0, 32'h0300_0000);
        x.fmask = 8'h40;
        @(negedge clk);
        issue = x;
        #1 chkb(stall, 1'b0);
        @(negedge clk);
        issue = '0;
        chku(steer, BFC_U_SINGLE);
        chkb(sb_busy, 1'b1);
        wait_free();
        chkv(cond_flags_reg, 32'h53f0_000a);
        slow = 1'b0;
        x.fmask = 8'h00;
        go(x);
        chku(steer, BFC_U_MULTI);
        wait_free();
        $display("test scoreboard done");
        @(negedge clk);
        rst_b = 1'b0;
        #1 chkv(cond_flags_reg, 32'h0);
        chku(steer, BFC_U_NONE);
        chkb(redir.valid, 1'b0);
        @(negedge clk);
        rst_b = 1'b1;
        $display("test reset done");
        complete_run();
    end
endmodule
